// file: iox16_pkg.sv
// Shared constants and types for the 16-bit I/O expander
`default_nettype none
package iox16_pkg;

  // -------------------------------------------------------------------
  // Register pair kinds (command byte = {kind, port})
  // -------------------------------------------------------------------
  localparam logic [1:0] KIND_IN  = 2'h0;
  localparam logic [1:0] KIND_OUT = 2'h1;
  localparam logic [1:0] KIND_POL = 2'h2;
  localparam logic [1:0] KIND_CFG = 2'h3;

  // -------------------------------------------------------------------
  // Values after reset
  // -------------------------------------------------------------------
  localparam logic [7:0] OUT_RST  = 8'hff;
  localparam logic [7:0] POL_RST  = 8'h00;
  localparam logic [7:0] CFG_RST  = 8'hff;
  localparam logic [2:0] PTR_RST  = 3'h0;

  // -------------------------------------------------------------------
  // Serial framing
  // -------------------------------------------------------------------
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_AFTER_START = 3'h1;
  localparam logic [2:0] BIT_LAST  = 3'h7;

  typedef enum logic [3:0] {
    LK_IDLE,
    LK_ADDR,
    LK_ADDR_ACK,
    LK_CMD,
    LK_CMD_ACK,
    LK_WDATA,
    LK_WDATA_ACK,
    LK_RDATA,
    LK_RDATA_ACK
  } iox16_link_st_t;

endpackage
`default_nettype wire

// file: iox16_xfer_if.sv
// Signals passed between the system-clock core and the serial link
`timescale 1ns/100ps
`default_nettype none
interface iox16_xfer_if;
  logic       start_tgl;  // Toggles on every START
  logic [6:0] addr;       // Own slave address
  logic [7:0] rd_data;    // Snapshot of the register to send
  logic       wr_tgl;     // Toggles per received data byte
  logic [2:0] wr_ptr;     // Register of that byte
  logic [7:0] wr_data;    // The byte itself
  logic       rd_tgl;     // Toggles per read snapshot request
  logic [2:0] rd_ptr;     // Register to snapshot
  logic       sda_low;    // Link wants SDA pulled low

  modport sys (
    output start_tgl, addr, rd_data,
    input  wr_tgl, wr_ptr, wr_data, rd_tgl, rd_ptr, sda_low
  );
  modport link (
    input  start_tgl, addr, rd_data,
    output wr_tgl, wr_ptr, wr_data, rd_tgl, rd_ptr, sda_low
  );
endinterface
`default_nettype wire

// file: iox16_sync.sv
// Two-flop level synchroniser, one per bit
`timescale 1ns/100ps
`default_nettype none
module iox16_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,    // Destination clock
  input  wire logic             i_arst_n, // Async reset, active low
  input  wire logic [WIDTH-1:0] i_d,      // Foreign-domain levels
  output logic      [WIDTH-1:0] o_q       // Synchronised levels
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } iox16_sync_st_t;

  iox16_sync_st_t r;
  iox16_sync_st_t next_r;

  always_comb begin
    next_r.s1 = i_d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_q = r.s2;
endmodule
`default_nettype wire

// file: iox16_link.sv
// Serial slave logic clocked by the bus clock line
`timescale 1ns/100ps
`default_nettype none
module iox16_link (
  input  wire logic  i_scl,    // Bus clock, clocks this module
  input  wire logic  i_arst_n, // Async reset, active low
  input  wire logic  i_sda,    // Bus data level
  iox16_xfer_if.link bus       // Core side
);
  typedef struct packed {
    iox16_pkg::iox16_link_st_t st;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic       rw;
    logic [2:0] ptr;
    logic       start_seen;
    logic       wr_tgl;
    logic [2:0] wr_ptr;
    logic [7:0] wr_data;
    logic       rd_tgl;
    logic [2:0] rd_ptr;
  } iox16_link_st_s_t;

  typedef struct packed {
    logic       sda_low;
    logic [7:0] tx;
  } iox16_link_tx_t;

  iox16_link_st_s_t r, next_r;
  iox16_link_tx_t   q, next_q;
  logic [7:0]       full;
  logic             last;
  logic [2:0]       alt_ptr;

  // -------------------------------------------------------------------
  // Receive side, rising clock edge
  // -------------------------------------------------------------------
  always_comb begin
    next_r = r;
    full = {r.sh[6:0], i_sda};
    last = (r.cnt == iox16_pkg::BIT_LAST);
    alt_ptr = {r.ptr[2:1], ~r.ptr[0]};
    next_r.sh = full;
    next_r.cnt = r.cnt + 3'h1;
    // Start toggle settles during the START hold time
    if (bus.start_tgl != r.start_seen) begin
      next_r.start_seen = bus.start_tgl;
      next_r.st = iox16_pkg::LK_ADDR;
      next_r.cnt = iox16_pkg::BIT_AFTER_START;
    end else begin
      case (r.st)
        iox16_pkg::LK_ADDR: if (last) begin
          next_r.rw = full[0];
          next_r.st = (full[7:1] == bus.addr) ? iox16_pkg::LK_ADDR_ACK
                                              : iox16_pkg::LK_IDLE;
        end
        iox16_pkg::LK_ADDR_ACK: begin
          next_r.cnt = iox16_pkg::BIT_FIRST;
          if (r.rw) begin
            next_r.st = iox16_pkg::LK_RDATA;
            next_r.rd_tgl = ~r.rd_tgl;
            next_r.rd_ptr = r.ptr;
          end else begin
            next_r.st = iox16_pkg::LK_CMD;
          end
        end
        iox16_pkg::LK_CMD: if (last) begin
          next_r.ptr = full[2:0];
          next_r.st = iox16_pkg::LK_CMD_ACK;
        end
        iox16_pkg::LK_CMD_ACK, iox16_pkg::LK_WDATA_ACK: begin
          next_r.cnt = iox16_pkg::BIT_FIRST;
          next_r.st = iox16_pkg::LK_WDATA;
        end
        iox16_pkg::LK_WDATA: if (last) begin
          next_r.wr_tgl = ~r.wr_tgl;
          next_r.wr_ptr = r.ptr;
          next_r.wr_data = full;
          next_r.ptr = alt_ptr;
          next_r.st = iox16_pkg::LK_WDATA_ACK;
        end
        iox16_pkg::LK_RDATA: if (last) begin
          next_r.st = iox16_pkg::LK_RDATA_ACK;
        end
        iox16_pkg::LK_RDATA_ACK: begin
          next_r.cnt = iox16_pkg::BIT_FIRST;
          if (!i_sda) begin
            next_r.ptr = alt_ptr;
            next_r.rd_tgl = ~r.rd_tgl;
            next_r.rd_ptr = alt_ptr;
            next_r.st = iox16_pkg::LK_RDATA;
          end else begin
            next_r.st = iox16_pkg::LK_IDLE;
          end
        end
        default: next_r.st = iox16_pkg::LK_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Transmit side, falling clock edge
  // -------------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.sda_low = 1'b0;
    case (r.st)
      iox16_pkg::LK_ADDR_ACK, iox16_pkg::LK_CMD_ACK,
      iox16_pkg::LK_WDATA_ACK: next_q.sda_low = 1'b1;
      iox16_pkg::LK_RDATA: begin
        if (r.cnt == iox16_pkg::BIT_FIRST) begin
          // Snapshot settled during the clock high time
          next_q.tx = {bus.rd_data[6:0], 1'b0};
          next_q.sda_low = ~bus.rd_data[7];
        end else begin
          next_q.tx = {q.tx[6:0], 1'b0};
          next_q.sda_low = ~q.tx[7];
        end
      end
      default: next_q.sda_low = 1'b0;
    endcase
  end

  always_ff @(posedge i_scl or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= '{st: iox16_pkg::LK_IDLE, ptr: iox16_pkg::PTR_RST, default: '0};
    end else begin
      r <= next_r;
    end
  end

  always_ff @(negedge i_scl or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign bus.wr_tgl  = r.wr_tgl;
  assign bus.wr_ptr  = r.wr_ptr;
  assign bus.wr_data = r.wr_data;
  assign bus.rd_tgl  = r.rd_tgl;
  assign bus.rd_ptr  = r.rd_ptr;
  assign bus.sda_low = q.sda_low;
endmodule
`default_nettype wire

// file: iox16_top.sv
// Two-wire-bus 16-bit I/O expander, system-clock core and top level
//
// Behaviour
// - Input pins: both drivers off
// - Push-pull output: drive per output bit
// - Open-drain: no high-side driver at all
// - First written byte is the register pointer
// - Each data byte toggles pointer within pair
// - Unlimited data bytes per write
// - Send data captured at ack rising edge
// - Further read bytes alternate within pair
// - STOP anywhere; last acked data stands
// - Input pin change asserts interrupt
// - Interrupt drops on return or read
// - Output pins never raise interrupt
// - Interrupt clear is per port
// - Output-to-input switch may interrupt spuriously
// - Bus idles high; START also taken mid-transfer
// - START and STOP from data edges, clock high
// - One bit per clock, data stable high
// - Receiver pulls data low during ack
// - Transmitter releases data after no-ack
// - Commands 0-7: input, output, polarity, config
// - Input regs show pins, ignore writes
// - Polarity bit inverts input as read
// - Config 1 input; reset ones, polarity zero
`timescale 1ns/100ps
`default_nettype none
module iox16_top #(
  parameter bit         OPEN_DRAIN    = 1'b0, // Open-drain pin variant
  parameter logic [3:0] SLAVE_ADDR_HI = 4'h4  // Fixed address bits
) (
  input  wire logic        i_sys_clk,    // System clock, 10 MHz
  input  wire logic        i_arst_n,     // Async reset, active low
  input  wire logic        i_scl,        // Bus clock line
  input  wire logic        i_sda,        // Bus data line level
  output logic             o_sda,        // Data line drive value
  output logic             o_sda_oe,     // High pulls data line low
  input  wire logic [2:0]  i_addr_strap, // Address strap pins
  input  wire logic [15:0] i_io_pin,     // Port pin levels
  output logic      [15:0] o_io_pin,     // Port pin drive value
  output logic      [15:0] o_io_pin_oe,  // Port pin drive enable
  output logic             o_int,        // Interrupt drive value
  output logic             o_int_oe      // High pulls interrupt low
);

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  typedef struct packed {
    logic            scl_q;
    logic            sda_q;
    logic            start_tgl;
    logic [6:0]      addr;
    logic            busy;
    logic            drive_ok;
    logic            sda_oe;
    logic [1:0][7:0] outp;
    logic [1:0][7:0] pol;
    logic [1:0][7:0] cfg;
    logic [1:0][7:0] in_ref;
    logic            ref_primed;
    logic [1:0]      warm;
    logic            wr_seen;
    logic            rd_seen;
    logic [7:0]      rd_data;
    logic [15:0]     pin_out;
    logic [15:0]     pin_oe;
    logic            int_oe;
  } iox16_core_st_t;

  iox16_core_st_t  r;
  iox16_core_st_t  next_r;
  iox16_xfer_if    bus ();

  logic [23:0]     syn;
  logic [1:0][7:0] pin;
  logic            scl;
  logic            sda;
  logic            wr_t;
  logic            rd_t;
  logic            sda_low;
  logic [2:0]      strap;
  logic            start;
  logic            stop;
  logic            wr_ev;
  logic            rd_ev;
  logic [15:0]     high_side_driver;
  logic [15:0]     low_side_driver;

  // -------------------------------------------------------------------
  // Register read decode
  // -------------------------------------------------------------------
  function automatic logic [7:0] iox16_read_val(
    input logic [2:0]      ptr,
    input logic [1:0][7:0] pins,
    input logic [1:0][7:0] pol,
    input logic [1:0][7:0] outp,
    input logic [1:0][7:0] cfg
  );
    case (ptr[2:1])
      iox16_pkg::KIND_IN:  iox16_read_val = pins[ptr[0]] ^ pol[ptr[0]];
      iox16_pkg::KIND_OUT: iox16_read_val = outp[ptr[0]];
      iox16_pkg::KIND_POL: iox16_read_val = pol[ptr[0]];
      default:             iox16_read_val = cfg[ptr[0]];
    endcase
  endfunction

  // -------------------------------------------------------------------
  // Crossings into the system clock
  // -------------------------------------------------------------------
  iox16_sync #(
    .WIDTH (24)
  ) u_sync (
    .i_clk    (i_sys_clk),
    .i_arst_n (i_arst_n),
    .i_d      ({i_addr_strap, bus.sda_low, bus.rd_tgl, bus.wr_tgl,
                i_sda, i_scl, i_io_pin}),
    .o_q      (syn)
  );

  iox16_link u_link (
    .i_scl    (i_scl),
    .i_arst_n (i_arst_n),
    .i_sda    (i_sda),
    .bus      (bus.link)
  );

  assign pin     = syn[15:0];
  assign scl     = syn[16];
  assign sda     = syn[17];
  assign wr_t    = syn[18];
  assign rd_t    = syn[19];
  assign sda_low = syn[20];
  assign strap   = syn[23:21];

  assign start = scl & r.scl_q & r.sda_q & ~sda;
  assign stop  = scl & r.scl_q & ~r.sda_q & sda;
  assign wr_ev = (wr_t != r.wr_seen);
  assign rd_ev = (rd_t != r.rd_seen);

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.scl_q = scl;
    next_r.sda_q = sda;
    next_r.addr = {SLAVE_ADDR_HI, strap};

    // Bus framing; data drive only after a clock low following START
    if (start) begin
      next_r.start_tgl = ~r.start_tgl;
      next_r.busy = 1'b1;
    end
    if (stop) begin
      next_r.busy = 1'b0;
    end
    if (start || stop) begin
      next_r.drive_ok = 1'b0;
    end else if (r.busy && r.scl_q && !scl) begin
      next_r.drive_ok = 1'b1;
    end
    next_r.sda_oe = sda_low & r.drive_ok & r.busy & ~start & ~stop;

    // Received byte; each one stands once its eighth bit is clocked in, before its ack
    if (wr_ev) begin
      next_r.wr_seen = wr_t;
      case (bus.wr_ptr[2:1])
        iox16_pkg::KIND_OUT: next_r.outp[bus.wr_ptr[0]] = bus.wr_data;
        iox16_pkg::KIND_POL: next_r.pol[bus.wr_ptr[0]] = bus.wr_data;
        iox16_pkg::KIND_CFG: next_r.cfg[bus.wr_ptr[0]] = bus.wr_data;
        default: next_r.wr_seen = wr_t;
      endcase
    end

    // Read snapshot; an input read rebases that port only
    if (rd_ev) begin
      next_r.rd_seen = rd_t;
      next_r.rd_data = iox16_read_val(bus.rd_ptr, pin, r.pol,
                                      r.outp, r.cfg);
      if (bus.rd_ptr[2:1] == iox16_pkg::KIND_IN) begin
        next_r.in_ref[bus.rd_ptr[0]] = pin[bus.rd_ptr[0]];
      end
    end
    // Prime the reference once the pin synchroniser holds real levels
    next_r.warm = {r.warm[0], 1'b1};
    if (!r.ref_primed) begin
      next_r.in_ref = pin;
      next_r.ref_primed = r.warm[1];
    end

    // Pin drivers; configuration 1 means input
    low_side_driver  = ~r.cfg & ~r.outp;
    high_side_driver = OPEN_DRAIN ? 16'h0000
                                  : (~r.cfg & r.outp);
    next_r.pin_out = high_side_driver;
    next_r.pin_oe  = high_side_driver | low_side_driver;

    // Interrupt: input pins that differ from last read contents
    next_r.int_oe = r.ref_primed
                    & (|(r.cfg & (pin ^ r.in_ref)));
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= '{outp:   {iox16_pkg::OUT_RST, iox16_pkg::OUT_RST},
             pol:    {iox16_pkg::POL_RST, iox16_pkg::POL_RST},
             cfg:    {iox16_pkg::CFG_RST, iox16_pkg::CFG_RST},
             default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign bus.start_tgl = r.start_tgl;
  assign bus.addr      = r.addr;
  assign bus.rd_data   = r.rd_data;

  assign o_sda       = 1'b0;
  assign o_sda_oe    = r.sda_oe;
  assign o_io_pin    = r.pin_out;
  assign o_io_pin_oe = r.pin_oe;
  assign o_int       = 1'b0;
  assign o_int_oe    = r.int_oe;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);

  sequence s_wr_kind(logic [1:0] kind);
    wr_ev && (bus.wr_ptr[2:1] == kind);
  endsequence

  sequence s_in_read;
    rd_ev ##0 (bus.rd_ptr[2:1] == iox16_pkg::KIND_IN);
  endsequence

  a_input_pins_hiz: assert property (
    1'b1 |=> ((o_io_pin_oe & $past(r.cfg)) == 16'h0000))
    else $error("input pin is being driven");

  a_output_pins_drive: assert property (
    !OPEN_DRAIN |=> (o_io_pin_oe == ~$past(r.cfg))
                    && ((o_io_pin & o_io_pin_oe) ==
                        ($past(r.outp) & o_io_pin_oe)))
    else $error("push-pull output pin not driven per output bit");

  a_open_drain_low: assert property (
    OPEN_DRAIN |=> (o_io_pin == 16'h0000)
                   && (o_io_pin_oe == (~$past(r.cfg) & ~$past(r.outp))))
    else $error("open-drain pin drove high or lost low drive");

  a_write_out_reg: assert property (
    s_wr_kind(iox16_pkg::KIND_OUT)
      |=> r.outp[$past(bus.wr_ptr[0])] == $past(bus.wr_data))
    else $error("output register not updated by write");

  a_input_reg_ro: assert property (
    s_wr_kind(iox16_pkg::KIND_IN) ##0 !rd_ev
      |=> $stable(r.outp) && $stable(r.pol) && $stable(r.cfg))
    else $error("write to input register changed state");

  a_read_rebases: assert property (
    s_in_read |=> (r.in_ref[$past(bus.rd_ptr[0])] ==
                   $past(pin[bus.rd_ptr[0]]))
                  && (r.in_ref[~$past(bus.rd_ptr[0])] ==
                      $past(r.in_ref[~bus.rd_ptr[0]])))
    else $error("input read did not rebase only its port");

  a_polarity_read: assert property (
    s_in_read |=> r.rd_data == ($past(pin[bus.rd_ptr[0]])
                                ^ r.pol[$past(bus.rd_ptr[0])]))
    else $error("input read ignores polarity inversion");

  a_int_on_change: assert property (
    r.ref_primed && ((r.cfg & (pin ^ r.in_ref)) != 16'h0000)
      |=> o_int_oe)
    else $error("input change did not raise interrupt");

  a_no_int_outputs: assert property (
    (r.cfg == 16'h0000) [*2] |=> !o_int_oe)
    else $error("interrupt raised with all pins outputs");

  a_idle_sda_free: assert property (
    !r.busy |=> !o_sda_oe)
    else $error("data line driven while bus idle");

  a_start_marks: assert property (
    start |=> r.busy && (r.start_tgl != $past(r.start_tgl))
              && !o_sda_oe)
    else $error("START not taken");

  a_stop_releases: assert property (
    stop |=> !r.busy ##1 !o_sda_oe [*2])
    else $error("STOP did not release data line");

  a_reset_values: assert property (
    !r.warm[1] |-> (r.cfg == {2{iox16_pkg::CFG_RST}})
                   && (r.pol == {2{iox16_pkg::POL_RST}})
                   && (r.outp == {2{iox16_pkg::OUT_RST}}))
    else $error("registers left reset with wrong values");

  a_write_pol_reg: assert property (
    s_wr_kind(iox16_pkg::KIND_POL)
      |=> r.pol[$past(bus.wr_ptr[0])] == $past(bus.wr_data))
    else $error("polarity register not updated by write");

  a_write_cfg_reg: assert property (
    s_wr_kind(iox16_pkg::KIND_CFG)
      |=> r.cfg[$past(bus.wr_ptr[0])] == $past(bus.wr_data))
    else $error("configuration register not updated by write");

  a_output_read: assert property (
    rd_ev && (bus.rd_ptr[2:1] == iox16_pkg::KIND_OUT)
      |=> r.rd_data == $past(r.outp[bus.rd_ptr[0]]))
    else $error("output register read not the stored value");

  a_int_released: assert property (
    r.ref_primed && ((r.cfg & (pin ^ r.in_ref)) == 16'h0000)
      |=> !o_int_oe)
    else $error("interrupt held with inputs at reference");

  a_other_port_held: assert property (
    s_in_read ##0 r.ref_primed
      ##0 ((r.cfg[~bus.rd_ptr[0]] & (pin[~bus.rd_ptr[0]]
            ^ r.in_ref[~bus.rd_ptr[0]])) != 8'h00)
      |=> o_int_oe)
    else $error("input read cleared the other port interrupt");

  a_ack_drives_sda: assert property (
    sda_low && r.drive_ok && r.busy && !start && !stop |=> o_sda_oe)
    else $error("acknowledge or data drive not passed to data line");

  a_start_waits_fall: assert property (
    start |=> !r.drive_ok)
    else $error("data drive enabled before clock low after START");

endmodule
`default_nettype wire

// file: iox16_mst.sv
// Behavioural two-wire bus master driving the expander
`timescale 1ns/100ps
`default_nettype none
module iox16_mst (
  input  wire logic i_sys_clk, // Bench clock, paces the bus
  input  wire logic i_sda,     // Resolved data line level
  output logic      o_scl,     // Bus clock, still between frames
  output logic      o_sda_low  // High pulls the data line low
);
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end
  // -------------------------------------------------------------------
  // Bus phases, quarter bit of 2 us
  // -------------------------------------------------------------------
  task automatic q();
    repeat (20) @(negedge i_sys_clk);
  endtask
  task automatic bit_x(input logic b, output logic s);
    o_sda_low = ~b;
    q();
    o_scl = 1'b1;
    q();
    s = i_sda;
    q();
    o_scl = 1'b0;
    q();
  endtask
  task automatic start();
    o_sda_low = 1'b0;
    q();
    o_scl = 1'b1;
    q();
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b0;
    q();
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b1;
    q();
    o_sda_low = 1'b0;
    q();
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, ack);
  endtask
  task automatic get(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(ack, s);
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the 16-bit I/O expander
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [6:0] A_PP = {4'h4, 3'h1};
  localparam logic [6:0] A_OD = {4'h4, 3'h2};
  localparam logic [6:0] A_NO = {4'h4, 3'h7};
  logic        i_sys_clk = 1'b0;
  logic        i_arst_n  = 1'b0;
  logic [15:0] ext       = 16'h0000;
  logic        scl, sda_low, oe_pp, oe_od, int_oe;
  logic        sda_v, int_v, od_int;
  logic [15:0] pin_val, pin_oe, od_val, od_oe;
  logic [7:0]  rd [4];
  int          mismatches = 0;
  int          tests_run  = 0;
  wire logic        sda    = ~(sda_low | oe_pp | oe_od);
  wire logic [15:0] pin    = (pin_oe & pin_val) | (~pin_oe & ext);
  wire logic [15:0] od_pin = ~od_oe & ext;
  always #50 i_sys_clk = ~i_sys_clk;
  iox16_top #(.OPEN_DRAIN(1'b0)) i_iox16_top (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_scl(scl), .i_sda(sda),
    .o_sda(sda_v), .o_sda_oe(oe_pp), .i_addr_strap(3'h1), .i_io_pin(pin),
    .o_io_pin(pin_val), .o_io_pin_oe(pin_oe), .o_int(int_v),
    .o_int_oe(int_oe));
  iox16_top #(.OPEN_DRAIN(1'b1)) i_iox16_top_od (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_scl(scl), .i_sda(sda),
    .o_sda(), .o_sda_oe(oe_od), .i_addr_strap(3'h2), .i_io_pin(od_pin),
    .o_io_pin(od_val), .o_io_pin_oe(od_oe), .o_int(), .o_int_oe(od_int));
  iox16_mst mst (.i_sys_clk(i_sys_clk), .i_sda(sda), .o_scl(scl),
    .o_sda_low(sda_low));
  // -------------------------------------------------------------------
  // Compares, bus cycles, closing
  // -------------------------------------------------------------------
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t value %h, expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t bit %b, expected %b", $time, g, e);
    end
  endtask
  task automatic set_ext(input logic [15:0] v);
    @(negedge i_sys_clk);
    ext = v;
  endtask
  task automatic wait_int(input logic e);
    int t;
    t = 0;
    while (int_oe !== e && t < 20) begin
      @(negedge i_sys_clk);
      t++;
    end
    chk_bit(e, int_oe);
    if (int_oe !== e) summarize();
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c,
                    input int n, input logic [23:0] d, input logic e);
    logic k;
    mst.start();
    mst.put({a, 1'b0}, k);
    chk_bit(e, k);
    mst.put(c, k);
    chk_bit(e, k);
    for (int i = 0; i < n; i++) begin
      mst.put(d[23-8*i -: 8], k);
      chk_bit(e, k);
    end
    mst.stop();
  endtask
  task automatic rd_regs(input logic [7:0] c, input int n);
    logic k;
    mst.start();
    mst.put({A_PP, 1'b0}, k);
    mst.put(c, k);
    mst.start();
    mst.put({A_PP, 1'b1}, k);
    chk_bit(1'b0, k);
    for (int i = 0; i < n; i++) mst.get(i == n - 1, rd[i]);
    chk_bit(1'b1, sda);
    mst.stop();
  endtask
  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic t_reset();
    chk_val(16'h0000, pin_oe);
    chk_bit(1'b0, int_oe);
    for (int c = 2; c < 8; c += 2) begin
      rd_regs(8'(c), 2);
      chk_val({2{(c == 4) ? 8'h00 : 8'hff}}, {rd[0], rd[1]});
    end
    $display("test reset done");
  endtask
  task automatic t_write();
    wr(A_PP, 8'h03, 3, 24'ha53c0f, 1'b0);
    wr(A_PP, 8'h06, 2, 24'h000000, 1'b0);
    wr(A_OD, 8'h03, 3, 24'ha53c0f, 1'b0);
    wr(A_OD, 8'h06, 2, 24'h000000, 1'b0);
    repeat (10) @(negedge i_sys_clk);
    chk_val(16'hffff, pin_oe);
    chk_val(16'h0f3c, pin_val);
    chk_val(16'h0000, od_val);
    chk_val(16'hf0c3, od_oe);
    rd_regs(8'h02, 3);
    chk_val(16'h3c0f, {rd[0], rd[1]});
    chk_val(16'h003c, {8'h00, rd[2]});
    rd_regs(8'h01, 2);
    chk_val(16'h0f3c, {rd[0], rd[1]});
    $display("test write done");
  endtask
  task automatic t_foreign();
    wr(A_NO, 8'h02, 1, 24'h550000, 1'b1);
    rd_regs(8'h02, 1);
    chk_val(16'h003c, {8'h00, rd[0]});
    $display("test foreign done");
  endtask
  task automatic t_pol();
    set_ext(16'h1234);
    wr(A_PP, 8'h06, 2, 24'hffff00, 1'b0);
    wr(A_PP, 8'h04, 2, 24'hff0000, 1'b0);
    rd_regs(8'h00, 2);
    chk_val(16'hcb12, {rd[0], rd[1]});
    wr(A_PP, 8'h00, 1, 24'h000000, 1'b0);
    rd_regs(8'h00, 1);
    chk_val(16'h00cb, {8'h00, rd[0]});
    wait_int(1'b0);
    $display("test polarity done");
  endtask
  task automatic t_int();
    set_ext(16'h123c);
    wait_int(1'b1);
    set_ext(16'h1234);
    wait_int(1'b0);
    set_ext(16'h9234);
    wait_int(1'b1);
    rd_regs(8'h00, 1);
    chk_bit(1'b1, int_oe);
    rd_regs(8'h01, 1);
    wait_int(1'b0);
    wr(A_PP, 8'h06, 1, 24'hfe0000, 1'b0);
    wr(A_PP, 8'h02, 1, 24'h3d0000, 1'b0);
    repeat (10) @(negedge i_sys_clk);
    chk_val(16'h9235, pin);
    chk_bit(1'b0, int_oe);
    chk_val(16'h0000, {13'h0, sda_v, int_v, od_int});
    $display("test interrupt done");
  endtask
  initial begin
    repeat (2) @(negedge i_sys_clk);
    i_arst_n = 1'b1;
    repeat (10) @(negedge i_sys_clk);
    t_reset();
    t_write();
    t_foreign();
    t_pol();
    t_int();
    summarize();
  end
endmodule
`default_nettype wire
